/* File: hdl/cpc_pkg.sv */
// cpc_pkg: constants and carriers for the channel poll chain attachment
package cpc_pkg;

	// ****************************************
	// register map (word byte addresses)
	// ****************************************
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;

	// control register fields
	localparam int CTRL_LEVEL_LSB = 0;
	localparam int CTRL_LEVEL_W   = 4;
	localparam int CTRL_IRQ_BIT   = 4;
	localparam int CTRL_CS_BIT    = 5;
	localparam int CTRL_BURST_BIT = 6;
	localparam int CTRL_DCB_BIT   = 7;
	localparam int CTRL_CONN_BIT  = 8;
	localparam int CTRL_LAST_BIT  = 9;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// status register fields
	localparam int STAT_STATE_LSB = 0;
	localparam int STAT_CAPT_BIT  = 4;
	localparam int STAT_PROP_BIT  = 5;
	localparam int STAT_BURST_BIT = 6;

	// poll identifier codes
	localparam logic [4:0] POLL_QUIESCENT = 5'h10;
	localparam logic [1:0] POLL_CS_LOW    = 2'h3;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic [4:0] poll_id;
		logic       poll;
		logic       poll_prime;
		logic       service_gate;
		logic       halt_machine_check;
	} cpc_tags_in_s;

	typedef struct packed {
		logic [15:0] request_in;
		logic        cs_request;
		logic        poll_propagate;
		logic        poll_return;
		logic        burst_return;
	} cpc_tags_out_s;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h1,
		ST_CAPT  = 4'h2,
		ST_SERV  = 4'h4,
		ST_PROP  = 4'h8
	} cpc_state_e;

endpackage

/* File: hdl/cpc_attach.sv */
// cpc_attach: poll group logic of a channel attachment
// ****************************************
// Behaviour
// - at most one of sixteen request lines is raised, line n for level n
// - requested level equals the level software prepared
// - cycle steal request tag raised whenever storage access is needed
// - 0xxxx selects a level, 10000 quiescent, 1XX11 cycle steal, else reserved
// - a poll is the rising edge of poll AND poll prime
// - capture when code matches prepared level, or cycle steal code while asking
// - an uncaptured poll arriving in idle is passed on through poll propagate
// - a silent or unconnected card propagates poll AND poll prime
// - interrupt or single cycle steal capture answered with poll return
// - burst capture answered with burst return; next service gate starts burst
// - burst return dropped at service gate rise of the final transfer
// - burst only when the control block asks; its fetches are single
// - a programmed transfer moves exactly one byte or word
// - interrupt service runs from capture until the identification word moves
// - cycle steal service ends after one transfer unless bursting
// - while a connected card is in capture or burst service, new polls are neither captured nor propagated
// - poll code, poll and poll prime recognised only in idle, or always when unconnected
// - first service gate rise after capture starts the service sequence
// - halt or machine check blocks propagation, clears requests, keeps level
// ****************************************
`timescale 1ns/1ps
module cpc_attach (
	input  wire logic                  clk_i,    // 50 MHz clock
	input  wire logic                  rst_i,    // sync reset, high
	input  wire logic [3:0]            adr_i,    // wishbone byte address
	input  wire logic [31:0]           dat_i,    // wishbone write data
	input  wire logic [3:0]            sel_i,    // wishbone byte select
	input  wire logic                  we_i,     // wishbone write
	input  wire logic                  cyc_i,    // wishbone cycle
	input  wire logic                  stb_i,    // wishbone strobe
	output logic      [31:0]           dat_o,    // wishbone read data
	output logic                       ack_o,    // wishbone acknowledge
	input  wire cpc_pkg::cpc_tags_in_s tags_i,   // channel tags in
	output cpc_pkg::cpc_tags_out_s     tags_o    // channel tags out
);

	// ****************************************
	// synchronisers
	// ****************************************
	cpc_pkg::cpc_tags_in_s sync1;
	cpc_pkg::cpc_tags_in_s sync2;
	logic                  chain_q;

	always_ff @(posedge clk_i) begin
		sync1 <= tags_i;
		sync2 <= sync1;
	end

	// ****************************************
	// decode helpers
	// ****************************************
	function automatic logic is_cs_poll(input logic [4:0] id);
		return id[4] && (id[1:0] == cpc_pkg::POLL_CS_LOW);
	endfunction

	function automatic logic is_lvl_poll(input logic [4:0] id,
	                                     input logic [3:0] lvl);
		return !id[4] && (id[3:0] == lvl);
	endfunction

	// ****************************************
	// registers and state
	// ****************************************
	logic [31:0]        ctrl;
	logic [31:0]        next_ctrl;
	logic               next_ack;
	logic [31:0]        next_dat;
	cpc_pkg::cpc_state_e state;
	cpc_pkg::cpc_state_e next_state;
	logic               capt_cs;
	logic               next_capt_cs;
	logic               bursting;
	logic               next_bursting;
	logic               sg_q;
	cpc_pkg::cpc_tags_out_s next_tags;

	logic       chain;
	logic       poll_edge;
	logic       sg_rise;
	logic [3:0] level;
	logic       want_irq;
	logic       want_cs;
	logic       want_burst;
	logic       connected;
	logic       capture;

	assign chain     = sync2.poll & sync2.poll_prime;
	assign poll_edge = chain & ~chain_q;
	assign sg_rise   = sync2.service_gate & ~sg_q;
	assign level     = ctrl[cpc_pkg::CTRL_LEVEL_LSB +: cpc_pkg::CTRL_LEVEL_W];
	assign connected = ctrl[cpc_pkg::CTRL_CONN_BIT];
	assign want_irq  = connected & ctrl[cpc_pkg::CTRL_IRQ_BIT];
	assign want_cs   = connected & ctrl[cpc_pkg::CTRL_CS_BIT];
	// control block fetch forces single transfers
	assign want_burst = ctrl[cpc_pkg::CTRL_BURST_BIT]
	                  & ~ctrl[cpc_pkg::CTRL_DCB_BIT];
	assign capture = poll_edge & connected
	               & ((want_irq & is_lvl_poll(sync2.poll_id, level))
	               |  (want_cs & is_cs_poll(sync2.poll_id)));

	// ****************************************
	// bus slave
	// ****************************************
	always_comb begin
		next_ctrl = ctrl;
		next_ack  = 1'b0;
		next_dat  = 32'h0000_0000;
		if (cyc_i && stb_i && !ack_o) begin
			next_ack = 1'b1;
			if (we_i && adr_i == cpc_pkg::REG_CTRL) begin
				for (int b = 0; b < 4; b++) begin
					if (sel_i[b]) begin
						next_ctrl[b*8 +: 8] = dat_i[b*8 +: 8];
					end
				end
			end else if (!we_i) begin
				unique case (adr_i)
					cpc_pkg::REG_CTRL:   next_dat = ctrl;
					cpc_pkg::REG_STATUS: next_dat = {25'h000_0000,
					                               bursting,
					                               tags_o.poll_propagate,
					                               capt_cs,
					                               4'(state)};
					default:             next_dat = 32'h0000_0000;
				endcase
			end
		end
		// single transfer: the service gate rise after capture ends it
		// hardware completion clears request bits; set by bus loses
		if (state == cpc_pkg::ST_CAPT && sg_rise && !bursting) begin
			if (capt_cs) begin
				next_ctrl[cpc_pkg::CTRL_CS_BIT] = 1'b0;
			end else begin
				next_ctrl[cpc_pkg::CTRL_IRQ_BIT] = 1'b0;
			end
		end
		if (state == cpc_pkg::ST_SERV && sg_rise && bursting
		    && ctrl[cpc_pkg::CTRL_LAST_BIT]) begin
			next_ctrl[cpc_pkg::CTRL_CS_BIT]   = 1'b0;
			next_ctrl[cpc_pkg::CTRL_LAST_BIT] = 1'b0;
		end
		if (sync2.halt_machine_check) begin
			// keep prepared level, drop requests
			next_ctrl[cpc_pkg::CTRL_IRQ_BIT]   = 1'b0;
			next_ctrl[cpc_pkg::CTRL_CS_BIT]    = 1'b0;
			next_ctrl[cpc_pkg::CTRL_LAST_BIT]  = 1'b0;
		end
	end

	// ****************************************
	// poll chain state machine
	// ****************************************
	always_comb begin
		next_state    = state;
		next_capt_cs  = capt_cs;
		next_bursting = bursting;
		unique case (state)
			cpc_pkg::ST_IDLE: begin
				if (capture) begin
					next_state    = cpc_pkg::ST_CAPT;
					next_capt_cs  = is_cs_poll(sync2.poll_id);
					next_bursting = is_cs_poll(sync2.poll_id)
					              & want_burst;
				end else if (poll_edge) begin
					next_state = cpc_pkg::ST_PROP;
				end
			end
			cpc_pkg::ST_PROP: begin
				if (!chain) begin
					next_state = cpc_pkg::ST_IDLE;
				end
			end
			cpc_pkg::ST_CAPT: begin
				if (sg_rise) begin
					if (bursting) begin
						// first gate rise starts the burst
						next_state = cpc_pkg::ST_SERV;
					end else begin
						// one transfer, then back to idle
						next_state = cpc_pkg::ST_IDLE;
					end
				end
			end
			cpc_pkg::ST_SERV: begin
				// burst repeats until the final transfer's gate rise
				if (sg_rise && ctrl[cpc_pkg::CTRL_LAST_BIT]) begin
					next_state    = cpc_pkg::ST_IDLE;
					next_bursting = 1'b0;
				end
			end
			default: next_state = cpc_pkg::ST_IDLE;
		endcase
		if (sync2.halt_machine_check) begin
			next_state    = cpc_pkg::ST_IDLE;
			next_bursting = 1'b0;
			next_capt_cs  = 1'b0;
		end
	end

	// ****************************************
	// channel tag outputs
	// ****************************************
	always_comb begin
		next_tags = '0;
		if (want_irq && !sync2.halt_machine_check) begin
			next_tags.request_in[level] = 1'b1;
		end
		next_tags.cs_request = want_cs & ~sync2.halt_machine_check;
		if (!connected) begin
			next_tags.poll_propagate = chain & ~sync2.halt_machine_check;
		end else begin
			next_tags.poll_propagate = (next_state == cpc_pkg::ST_PROP)
			                         & ~sync2.halt_machine_check;
		end
		if (next_state == cpc_pkg::ST_CAPT) begin
			// poll code held by channel until answered
			next_tags.poll_return  = ~next_bursting;
			next_tags.burst_return = next_bursting;
		end else if (next_state == cpc_pkg::ST_SERV) begin
			next_tags.burst_return = next_bursting;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl     <= cpc_pkg::CTRL_RESET;
			ack_o    <= 1'b0;
			dat_o    <= 32'h0000_0000;
			state    <= cpc_pkg::ST_IDLE;
			capt_cs  <= 1'b0;
			bursting <= 1'b0;
			chain_q  <= 1'b0;
			sg_q     <= 1'b0;
			tags_o   <= '0;
		end else begin
			ctrl     <= next_ctrl;
			ack_o    <= next_ack;
			dat_o    <= next_dat;
			state    <= next_state;
			capt_cs  <= next_capt_cs;
			bursting <= next_bursting;
			chain_q  <= chain;
			sg_q     <= sync2.service_gate;
			tags_o   <= next_tags;
		end
	end

endmodule // cpc_attach

/* File: tb/cpc_attach_monitor.sv */
// checker of the attachment's port behaviour
`timescale 1ns/1ps
module cpc_attach_monitor (
	input wire logic                   clk_i,  // clock
	input wire logic                   rst_i,  // reset
	input wire logic                   cyc_i,  // bus cycle
	input wire logic                   stb_i,  // bus strobe
	input wire logic                   ack_o,  // bus ack
	input wire cpc_pkg::cpc_tags_in_s  tags_i, // channel tags in
	input wire cpc_pkg::cpc_tags_out_s tags_o  // channel tags out
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire logic poll_and = tags_i.poll & tags_i.poll_prime;
	wire logic any_ans = tags_o.poll_return | tags_o.burst_return
		| tags_o.poll_propagate;
	AST_ONE_LINE: assert property ($onehot0(tags_o.request_in))
		else $error("several request lines");
	AST_RET_EXCL: assert property (!(tags_o.poll_return && tags_o.burst_return))
		else $error("both returns high");
	AST_PROP_EXCL: assert property (tags_o.poll_propagate |->
		!tags_o.poll_return && !tags_o.burst_return) else $error("prop and return");
	AST_ANSWER: assert property ($rose(poll_and) && !tags_i.halt_machine_check
		|-> ##[3:5] any_ans) else $error("poll not answered");
	AST_NO_SPONT: assert property ($rose(any_ans) |-> $past(poll_and, 2))
		else $error("answer without poll");
	AST_SG_DROP: assert property ($rose(tags_i.service_gate)
		&& tags_o.poll_return |-> ##[3:5] !tags_o.poll_return)
		else $error("poll return kept");
	AST_HALT: assert property (tags_i.halt_machine_check [*5] |-> !any_ans
		&& tags_o.request_in == 16'h0000 && !tags_o.cs_request)
		else $error("halt did not clear");
	AST_ACK: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("no ack");
	AST_ACK_ONE: assert property (ack_o |=> !ack_o)
		else $error("ack too long");
endmodule // cpc_attach_monitor

bind cpc_attach cpc_attach_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .tags_i(tags_i),
	.tags_o(tags_o));

/* File: tb/cpc_chan_model.sv */
// channel side model: poll chain and service gate
`timescale 1ns/1ps
module cpc_chan_model (
	input  wire logic                   clk_i,  // clock
	input  wire cpc_pkg::cpc_tags_out_s dev_i,  // device tags
	output cpc_pkg::cpc_tags_in_s       chan_o  // channel tags
);
	initial begin
		chan_o = '0;
		chan_o.poll_id = cpc_pkg::POLL_QUIESCENT;
	end
	task automatic gate();
		@(posedge clk_i) chan_o.service_gate <= 1'b1;
		repeat (6) @(posedge clk_i);
		chan_o.service_gate <= 1'b0;
		repeat (6) @(posedge clk_i);
	endtask
	task automatic poll(input logic [4:0] id);
		int k;
		@(posedge clk_i) chan_o.poll_id <= id;
		@(posedge clk_i) begin
			chan_o.poll <= 1'b1;
			chan_o.poll_prime <= 1'b1;
		end
		k = 0;
		do @(posedge clk_i);
		while (!(dev_i.poll_return | dev_i.burst_return
			| dev_i.poll_propagate) && k++ < 20);
		chan_o.poll <= 1'b0;
		chan_o.poll_prime <= 1'b0;
		chan_o.poll_id <= cpc_pkg::POLL_QUIESCENT;
		if (dev_i.poll_return)
			gate();
		repeat (6) @(posedge clk_i);
	endtask
	task automatic halt();
		@(posedge clk_i) chan_o.halt_machine_check <= 1'b1;
		repeat (8) @(posedge clk_i);
		chan_o.halt_machine_check <= 1'b0;
		repeat (6) @(posedge clk_i);
	endtask
endmodule // cpc_chan_model

/* File: tb/cpc_attach_tb.sv */
// self-checking bench of the poll chain attachment
`timescale 1ns/1ps
module cpc_attach_tb;
	logic                   clk_i = 1'b0;
	logic                   rst_i = 1'b1;
	logic [3:0]             adr_i = 4'h0;
	logic [31:0]            dat_i = 32'h0000_0000;
	logic [3:0]             sel_i = 4'hf;
	logic                   we_i = 1'b0;
	logic                   cyc_i = 1'b0;
	logic                   stb_i = 1'b0;
	logic [31:0]            dat_o;
	logic                   ack_o;
	cpc_pkg::cpc_tags_in_s  tags_i;
	cpc_pkg::cpc_tags_out_s tags_o;
	logic [31:0]            rnd = 32'h0000_c2bf;
	logic [16:0]            req_q = 17'h0_0000;
	logic [2:0]             ans_q = 3'h0;
	logic [3:0]             lvl;
	logic [31:0]            q_rd[$];
	logic [16:0]            q_req[$];
	logic [2:0]             q_ans[$];
	int                     n_mismatch = 0;
	int                     checks = 0;
	int                     cycles = 0;
	always #10 clk_i = ~clk_i;
	cpc_attach i_dut (.clk_i, .rst_i, .adr_i, .dat_i, .sel_i, .we_i, .cyc_i,
		.stb_i, .dat_o, .ack_o, .tags_i, .tags_o);
	cpc_chan_model i_chan (.clk_i, .dev_i(tags_o), .chan_o(tags_i));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_i) begin
			cyc_i <= 1'b1;
			stb_i <= 1'b1;
			we_i <= w;
			adr_i <= a;
			dat_i <= d;
		end
		k = 0;
		do @(posedge clk_i);
		while (!ack_o && k++ < 20);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task automatic tally_and_finish();
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ****************************************
	// result watcher
	// ****************************************
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
		if (ack_o && !we_i)
			cmp(dat_o, q_rd.size() ? q_rd.pop_front() : 'x);
		if (!rst_i && {tags_o.request_in, tags_o.cs_request} !== req_q)
			cmp({tags_o.request_in, tags_o.cs_request},
				q_req.size() ? q_req.pop_front() : 'x);
		if (!rst_i && ans_q == 3'h0 && {tags_o.burst_return,
			tags_o.poll_return, tags_o.poll_propagate} != 3'h0)
			cmp({tags_o.burst_return, tags_o.poll_return,
				tags_o.poll_propagate}, q_ans.pop_front());
		req_q <= {tags_o.request_in, tags_o.cs_request};
		ans_q <= {tags_o.burst_return, tags_o.poll_return, tags_o.poll_propagate};
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		q_rd.push_back(32'h0000_0000);
		wb(1'b0, cpc_pkg::REG_CTRL, 32'h0000_0000);
		q_rd.push_back(32'h0000_0001);
		wb(1'b0, cpc_pkg::REG_STATUS, 32'h0000_0000);
		wb(1'b1, 4'hc, 32'hffff_ffff);
		q_rd.push_back(32'h0000_0000);
		wb(1'b0, 4'hc, 32'h0000_0000);
		q_ans.push_back(3'h1);
		i_chan.poll(5'h00);
		for (int l = 0; l < 16; l++) begin
			lvl = l[3:0];
			rnd = xs(rnd);
			q_req.push_back({16'h0001 << lvl, 1'b0});
			wb(1'b1, cpc_pkg::REG_CTRL, 32'h0000_0110 | l);
			q_ans.push_back(3'h1);
			i_chan.poll({1'b0, lvl ^ (rnd[3:0] | 4'h1)});
			q_ans.push_back(3'h2);
			q_req.push_back(17'h0_0000);
			i_chan.poll({1'b0, lvl});
		end
		for (int m = 0; m < 3; m++) begin
			rnd = xs(rnd);
			q_req.push_back(17'h0_0001);
			wb(1'b1, cpc_pkg::REG_CTRL, m == 0 ? 32'h0000_0120 :
				m == 1 ? 32'h0000_0160 : 32'h0000_01e0);
			q_ans.push_back(3'h1);
			i_chan.poll(5'h14);
			q_ans.push_back(m == 1 ? 3'h4 : 3'h2);
			q_req.push_back(17'h0_0000);
			i_chan.poll({1'b1, rnd[1:0], 2'b11});
			if (m == 1) begin
				i_chan.gate();
				cmp(tags_o.burst_return, 1'b1);
				wb(1'b1, cpc_pkg::REG_CTRL, 32'h0000_0340);
				i_chan.gate();
				cmp(tags_o.burst_return, 1'b0);
			end
		end
		q_req.push_back({16'h0400, 1'b0});
		wb(1'b1, cpc_pkg::REG_CTRL, 32'h0000_011a);
		q_req.push_back(17'h0_0000);
		i_chan.halt();
		q_rd.push_back(32'h0000_010a);
		wb(1'b0, cpc_pkg::REG_CTRL, 32'h0000_0000);
		sel_i <= 4'h1;
		wb(1'b1, cpc_pkg::REG_CTRL, 32'hffff_fe05);
		sel_i <= 4'hf;
		q_rd.push_back(32'h0000_0105);
		wb(1'b0, cpc_pkg::REG_CTRL, 32'h0000_0000);
		q_ans.push_back(3'h1);
		i_chan.poll(cpc_pkg::POLL_QUIESCENT);
		repeat (10) @(posedge clk_i);
		tally_and_finish();
	end
endmodule // cpc_attach_tb
